// File: sbpa_top.v
// Operation
// - first port with traffic becomes active
// - other port ignored until five idle minutes
// - after expiry next talking port wins
// - bit 6 is unlatched master summary
// - summary is OR of enabled status bits
// - service-request mask gates the summary
// - event summary set by enabled events
// - event enable mask gates event summary
// - message-available follows output buffer occupancy
// - eoi or newline ends command, path root
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sbpa_map.vh"
module sbpa_top #(
  parameter [39:0] IDLE_CYCLES = `SBPA_IDLE_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // command port a
  input  wire        port_a_valid,
  input  wire [7:0]  port_a_data,
  input  wire        port_a_eoi,
  // command port b
  input  wire        port_b_valid,
  input  wire [7:0]  port_b_data,
  input  wire        port_b_eoi,
  // status sources
  input  wire [7:0]  out_msg_count,
  input  wire [7:0]  stb_aux,
  input  wire [7:0]  std_event,
  // accepted command stream
  output wire        cmd_valid,
  output wire [7:0]  cmd_data,
  output wire        cmd_end,
  output wire        path_root,
  output wire [1:0]  port_active,
  output wire        irq
);
  reg  [7:0]  sre;
  reg  [7:0]  esr;
  reg  [7:0]  ese;
  wire [`SBPA_IRQ_W-1:0] irq_sts;
  reg  [`SBPA_IRQ_W-1:0] irq_en;
  reg         aw_held;
  reg  [7:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         mss_q;
  reg  [7:0]  stb;
  reg  [7:0]  next_esr;
  reg  [31:0] rd_word;
  reg         rd_hit;
  reg         wr_hit;

  wire        acc_valid;
  wire [7:0]  acc_data;
  wire        acc_eoi;
  wire        active_a;
  wire        active_b;
  wire        acquired;
  wire        expired;
  wire        mav;
  wire        esb;
  wire        mss;

  // port ownership and idle release
  sbpa_port_arb #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_arb (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .a_valid   (port_a_valid),
    .a_data    (port_a_data),
    .a_eoi     (port_a_eoi),
    .b_valid   (port_b_valid),
    .b_data    (port_b_data),
    .b_eoi     (port_b_eoi),
    .acc_valid (acc_valid),
    .acc_data  (acc_data),
    .acc_eoi   (acc_eoi),
    .active_a  (active_a),
    .active_b  (active_b),
    .acquired  (acquired),
    .expired   (expired)
  );

  // terminator detection on the accepted stream
  sbpa_term u_term (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (acc_valid),
    .in_data   (acc_data),
    .in_eoi    (acc_eoi),
    .cmd_valid (cmd_valid),
    .cmd_data  (cmd_data),
    .cmd_end   (cmd_end),
    .path_root (path_root)
  );

  assign port_active = {active_b, active_a};

  // status byte assembly, all live
  assign mav = (out_msg_count != 8'h00);
  assign esb = |(esr & ese);
  always @* begin
    stb                = stb_aux;
    stb[`SBPA_STB_MAV] = mav;
    stb[`SBPA_STB_ESB] = esb;
    stb[`SBPA_STB_MSS] = 1'b0;
  end
  // summary excludes its own position
  assign mss = |(stb & sre);

  // axi handshake: each channel free until captured
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire wr_go   = (aw_held | aw_fire) & (w_held | w_fire);
  wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire        wr_lo   = wr_go & wr_strb[0];

  // register decode for writes
  always @* begin
    case (wr_addr)
      `SBPA_OFF_SRE,
      `SBPA_OFF_ESE,
      `SBPA_OFF_CTRL,
      `SBPA_OFF_IRQ_CLR,
      `SBPA_OFF_IRQ_EN: wr_hit = 1'b1;
      default:          wr_hit = 1'b0;
    endcase
  end

  // register decode for reads
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `SBPA_OFF_STB:     rd_word[7:0] = {stb[7], mss, stb[5:0]};
      `SBPA_OFF_SRE:     rd_word[7:0] = sre;
      `SBPA_OFF_ESR:     rd_word[7:0] = esr;
      `SBPA_OFF_ESE:     rd_word[7:0] = ese;
      `SBPA_OFF_CTRL:    rd_word      = 32'h0000_0000;
      `SBPA_OFF_PORT:    rd_word[1:0] = port_active;
      `SBPA_OFF_IRQ_STS: rd_word[`SBPA_IRQ_W-1:0] = irq_sts;
      `SBPA_OFF_IRQ_EN:  rd_word[`SBPA_IRQ_W-1:0] = irq_en;
      default:           rd_hit       = 1'b0;
    endcase
  end

  // write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SBPA_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SBPA_RESP_OKAY : `SBPA_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // read channel, data registered at address capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SBPA_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `SBPA_RESP_OKAY : `SBPA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // mask registers hold until rewritten
  always @(posedge aclk) begin
    if (!aresetn) begin
      sre    <= `SBPA_SRE_RST;
      ese    <= `SBPA_ESE_RST;
      irq_en <= `SBPA_IRQ_EN_RST;
    end else if (wr_lo) begin
      if (wr_addr == `SBPA_OFF_SRE) begin
        sre <= wr_data[7:0];
      end
      if (wr_addr == `SBPA_OFF_ESE) begin
        ese <= wr_data[7:0];
      end
      if (wr_addr == `SBPA_OFF_IRQ_EN) begin
        irq_en <= wr_data[`SBPA_IRQ_W-1:0];
      end
    end
  end

  // event register: read or control write clears, new event wins
  always @* begin
    next_esr = esr;
    if (ar_fire && s_axi_araddr == `SBPA_OFF_ESR) begin
      next_esr = 8'h00;
    end
    if (wr_lo && wr_addr == `SBPA_OFF_CTRL && wr_data[`SBPA_CTRL_ESR_CLR]) begin
      next_esr = 8'h00;
    end
    next_esr = next_esr | std_event;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      esr <= 8'h00;
    end else begin
      esr <= next_esr;
    end
  end

  // previous summary, for the rising-edge event
  always @(posedge aclk) begin
    if (!aresetn) begin
      mss_q <= 1'b0;
    end else begin
      mss_q <= mss;
    end
  end

  // events that set a sticky bit, and bits cleared by software this cycle
  wire                   mss_rise = mss & ~mss_q;
  wire [`SBPA_IRQ_W-1:0] irq_set  = {mss_rise, cmd_end, expired, acquired};
  wire                   clr_go   = wr_lo && (wr_addr == `SBPA_OFF_IRQ_CLR);
  wire [`SBPA_IRQ_W-1:0] irq_clr  = clr_go ? wr_data[`SBPA_IRQ_W-1:0] : {`SBPA_IRQ_W{1'b0}};

  // one sticky flag per event, set beats clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `SBPA_IRQ_W; gi = gi + 1) begin : g_irq
      reg flag;
      always @(posedge aclk) begin
        if (!aresetn) begin
          flag <= 1'b0;
        end else begin
          flag <= (flag & ~irq_clr[gi]) | irq_set[gi];
        end
      end
      assign irq_sts[gi] = flag;
    end
  endgenerate

  // level interrupt while an enabled bit is pending
  assign irq = |(irq_sts & irq_en);

  // protection bits carry no meaning here
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, w_strb[3:1]};
endmodule // sbpa_top
`default_nettype wire

// File: sbpa_map.vh
`ifndef SBPA_MAP_VH
`define SBPA_MAP_VH

// register byte offsets on the axi4-lite slave
`define SBPA_OFF_STB      8'h00
`define SBPA_OFF_SRE      8'h04
`define SBPA_OFF_ESR      8'h08
`define SBPA_OFF_ESE      8'h0C
`define SBPA_OFF_CTRL     8'h10
`define SBPA_OFF_PORT     8'h14
`define SBPA_OFF_IRQ_STS  8'h18
`define SBPA_OFF_IRQ_CLR  8'h1C
`define SBPA_OFF_IRQ_EN   8'h20

// status byte bit positions
`define SBPA_STB_MAV      4
`define SBPA_STB_ESB      5
`define SBPA_STB_MSS      6

// interrupt status bit positions
`define SBPA_IRQ_ACQ      0
`define SBPA_IRQ_EXP      1
`define SBPA_IRQ_TERM     2
`define SBPA_IRQ_MSS      3
`define SBPA_IRQ_W        4

// reset values
`define SBPA_SRE_RST      8'h00
`define SBPA_ESE_RST      8'h00
`define SBPA_IRQ_EN_RST   4'h0

// control register bit: write one clears the event register
`define SBPA_CTRL_ESR_CLR 0

// terminator character
`define SBPA_CHAR_NL      8'h0A

// axi responses
`define SBPA_RESP_OKAY    2'b00
`define SBPA_RESP_SLVERR  2'b10

// idle interval before the active port is released
`define SBPA_IDLE_MINUTES 40'd5
`define SBPA_NS_PER_MIN   40'd60000000000
`define SBPA_CLK_NS       40'd4
`define SBPA_IDLE_CYCLES  (`SBPA_IDLE_MINUTES * `SBPA_NS_PER_MIN / `SBPA_CLK_NS)

`endif

// File: sbpa_port_arb.v
`timescale 1ns/1ns
`default_nettype none
module sbpa_port_arb #(
  parameter [39:0] IDLE_CYCLES = 40'd1
) (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       a_valid,
  input  wire [7:0] a_data,
  input  wire       a_eoi,
  input  wire       b_valid,
  input  wire [7:0] b_data,
  input  wire       b_eoi,
  output reg        acc_valid,
  output reg  [7:0] acc_data,
  output reg        acc_eoi,
  output wire       active_a,
  output wire       active_b,
  output reg        acquired,
  output reg        expired
);
  localparam [2:0] ST_FREE = 3'b001;
  localparam [2:0] ST_A    = 3'b010;
  localparam [2:0] ST_B    = 3'b100;

  reg  [2:0]  state;
  reg  [39:0] idle_cnt;
  wire        free_now = (state == ST_FREE);
  // port a wins a tie when both speak in the same free cycle
  wire        take_a   = a_valid & (free_now | (state == ST_A));
  wire        take_b   = b_valid & ((free_now & ~a_valid) | (state == ST_B));

  assign active_a = (state == ST_A);
  assign active_b = (state == ST_B);

  // ownership state, idle counter and forwarded byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_FREE;
      idle_cnt  <= 40'd0;
      acc_valid <= 1'b0;
      acc_data  <= 8'h00;
      acc_eoi   <= 1'b0;
      acquired  <= 1'b0;
      expired   <= 1'b0;
    end else begin
      acc_valid <= take_a | take_b;
      acc_data  <= take_a ? a_data : b_data;
      acc_eoi   <= take_a ? a_eoi : (take_b & b_eoi);
      acquired  <= 1'b0;
      expired   <= 1'b0;
      case (state)
        ST_FREE: begin
          idle_cnt <= 40'd0;
          if (a_valid) begin
            state    <= ST_A;
            acquired <= 1'b1;
          end else if (b_valid) begin
            state    <= ST_B;
            acquired <= 1'b1;
          end
        end
        ST_A, ST_B: begin
          if (take_a | take_b) begin
            idle_cnt <= 40'd0;
          end else if (idle_cnt == IDLE_CYCLES - 40'd1) begin
            state    <= ST_FREE;
            idle_cnt <= 40'd0;
            expired  <= 1'b1;
          end else begin
            idle_cnt <= idle_cnt + 40'd1;
          end
        end
        default: begin
          state    <= ST_FREE;
          idle_cnt <= 40'd0;
        end
      endcase
    end
  end
endmodule // sbpa_port_arb
`default_nettype wire

// File: sbpa_term.v
`timescale 1ns/1ns
`default_nettype none
`include "sbpa_map.vh"
module sbpa_term (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       in_valid,
  input  wire [7:0] in_data,
  input  wire       in_eoi,
  output reg        cmd_valid,
  output reg  [7:0] cmd_data,
  output reg        cmd_end,
  output reg        path_root
);
  wire is_nl = (in_data == `SBPA_CHAR_NL);

  // newline is swallowed; eoi ends the message in the same cycle as its byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_valid <= 1'b0;
      cmd_data  <= 8'h00;
      cmd_end   <= 1'b0;
      path_root <= 1'b0;
    end else begin
      cmd_valid <= in_valid & ~is_nl;
      cmd_data  <= in_data;
      cmd_end   <= in_valid & (is_nl | in_eoi);
      path_root <= in_valid & (is_nl | in_eoi);
    end
  end
endmodule // sbpa_term
`default_nettype wire

// File: sbpa_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbpa_ctl_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic       sel_b,
  input  wire logic [7:0] tx_byte,
  input  wire logic       eoi_in,
  output var  logic       port_a_valid,
  output var  logic [7:0] port_a_data,
  output var  logic       port_a_eoi,
  output var  logic       port_b_valid,
  output var  logic [7:0] port_b_data,
  output var  logic       port_b_eoi
);
  // one byte per request; idle data toggles so stale bytes never look valid
  always @(posedge aclk) begin
    if (!aresetn) begin
      {port_a_valid, port_a_eoi, port_b_valid, port_b_eoi} <= 4'h0;
      port_a_data <= 8'h00;
      port_b_data <= 8'h00;
    end else begin
      port_a_valid <= go && !sel_b;
      port_b_valid <= go && sel_b;
      port_a_eoi   <= go && !sel_b && eoi_in;
      port_b_eoi   <= go && sel_b && eoi_in;
      port_a_data  <= (go && !sel_b) ? tx_byte : ~port_a_data;
      port_b_data  <= (go && sel_b) ? tx_byte : ~port_b_data;
    end
  end
endmodule // sbpa_ctl_model
`default_nettype wire

// File: sbpa_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbpa_map.vh"
module sbpa_chk #(
  parameter [39:0] IDLE_CYCLES = 40'd1
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       port_a_valid,
  input wire logic [7:0] port_a_data,
  input wire logic       port_b_valid,
  input wire logic [7:0] port_b_data,
  input wire logic       port_b_eoi,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_end,
  input wire logic       path_root,
  input wire logic [1:0] port_active,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] out_msg_count
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bytes taken on the active port
  sequence a_take_s; port_a_valid && port_active == 2'h1; endsequence
  sequence b_take_s; port_b_valid && port_active == 2'h2; endsequence
  one_port_a: assert property (port_active != 2'h3)
    else $error("both ports active");
  acq_first_a: assert property (port_a_valid && port_active == 2'h0 |=> port_active == 2'h1)
    else $error("port a not acquired");
  acq_next_a: assert property (port_b_valid && !port_a_valid && port_active == 2'h0
    |=> port_active == 2'h2)
    else $error("port b not acquired");
  hold_other_a: assert property (port_b_valid && port_active == 2'h1 |=> port_active != 2'h2)
    else $error("other port taken while busy");
  hold_idle_a: assert property (a_take_s |=> port_active == 2'h1 [*8])
    else $error("active port dropped early");
  cmd_pass_a: assert property (a_take_s ##0 (port_a_data != `SBPA_CHAR_NL)
    |-> ##2 cmd_valid && cmd_data == $past(port_a_data, 2))
    else $error("accepted byte not passed");
  term_end_a: assert property (b_take_s ##0 (port_b_eoi || port_b_data == `SBPA_CHAR_NL)
    |-> ##2 cmd_end)
    else $error("terminator not seen");
  path_pair_a: assert property (path_root == cmd_end)
    else $error("path root not with end");
  mav_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SBPA_OFF_STB
    |=> s_axi_rdata[`SBPA_STB_MAV] == ($past(out_msg_count) != 8'h00))
    else $error("message bit wrong");
endmodule // sbpa_chk
bind sbpa_top sbpa_chk #(.IDLE_CYCLES(IDLE_CYCLES)) sbpa_chk_inst (.*);
`default_nettype wire

// File: test_status_byte_and_port_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbpa_map.vh"
module test_status_byte_and_port_arbiter;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_byte = 8'h00;
  logic [7:0]  out_msg_count = 8'h00, stb_aux = 8'h00, std_event = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0, sel_b = 1'h0, eoi_in = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cmd_valid, cmd_end, path_root, irq, port_a_valid, port_a_eoi, port_b_valid, port_b_eoi;
  logic [7:0]  port_a_data, port_b_data, cmd_data;
  logic [1:0]  s_axi_bresp, s_axi_rresp, port_active, r, br;
  int          num_errors = 0, tests_run = 0;
  sbpa_top #(.IDLE_CYCLES(40'd20)) sbpa_top_inst (.*);
  sbpa_ctl_model sbpa_ctl_model_inst (.*);
  // clock
  always #2 aclk = ~aclk;
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic timeout;
    num_errors++;
    $display("unexpected at %0t: bus timeout", $time);
    end_of_test;
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 50) timeout;
  endtask
  // axi4-lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 50) timeout;
  endtask
  // one byte from the far-side controller; t says whether the block should take it
  task automatic send(input logic b, input logic [7:0] v, input logic e, input logic t);
    logic nl;
    nl = (v == `SBPA_CHAR_NL);
    @(posedge aclk);
    {go, sel_b, eoi_in, tx_byte} <= {1'h1, b, e, v};
    @(posedge aclk);
    go <= 1'h0;
    repeat (3) @(posedge aclk);
    chk({cmd_valid, cmd_end, path_root}, {t & ~nl, t & (e | nl), t & (e | nl)});
    if (t && !nl) chk(cmd_data, v);
  endtask
  task automatic t_arb;
    int n;
    send(1'h0, 8'h41, 1'h0, 1'h1);
    chk(port_active, 2'h1);
    rd(`SBPA_OFF_PORT, d, r);
    chk(d, 32'h1);
    chk(r, `SBPA_RESP_OKAY);
    send(1'h0, 8'h44, 1'h0, 1'h1);
    send(1'h1, 8'h42, 1'h0, 1'h0);
    chk(port_active, 2'h1);
    for (n = 0; n < 60 && port_active !== 2'h0; n++) @(posedge aclk);
    chk(port_active, 2'h0);
    if (port_active !== 2'h0) timeout;
    send(1'h1, `SBPA_CHAR_NL, 1'h0, 1'h1);
    chk(port_active, 2'h2);
    send(1'h1, 8'h43, 1'h1, 1'h1);
  endtask
  task automatic t_status;
    stb_aux <= 8'h81;
    wr(`SBPA_OFF_SRE, 32'h0);
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'h81);
    wr(`SBPA_OFF_SRE, 32'h80);
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'hC1);
    wr(`SBPA_OFF_SRE, 32'h10);
    out_msg_count <= 8'h02;
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'hD1);
    out_msg_count <= 8'h00;
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'h81);
    rd(`SBPA_OFF_SRE, d, r);
    chk(d, 32'h10);
  endtask
  task automatic t_event;
    @(posedge aclk);
    std_event <= 8'h04;
    @(posedge aclk);
    std_event <= 8'h00;
    wr(`SBPA_OFF_ESE, 32'h0);
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'h81);
    wr(`SBPA_OFF_ESE, 32'h4);
    wr(`SBPA_OFF_SRE, 32'h20);
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'hE1);
    rd(`SBPA_OFF_ESR, d, r);
    chk(d, 32'h4);
    rd(`SBPA_OFF_ESR, d, r);
    chk(d, 32'h0);
    rd(8'h40, d, r);
    chk(r, `SBPA_RESP_SLVERR);
    wr(`SBPA_OFF_STB, 32'hFF);
    chk(br, `SBPA_RESP_SLVERR);
    @(posedge aclk);
    std_event <= 8'h04;
    @(posedge aclk);
    std_event <= 8'h00;
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'hE1);
    wr(`SBPA_OFF_CTRL, 32'h1);
    chk(br, `SBPA_RESP_OKAY);
    rd(`SBPA_OFF_STB, d, r);
    chk(d, 32'h81);
  endtask
  task automatic t_irq;
    wr(`SBPA_OFF_IRQ_EN, 32'h4);
    chk(irq, 1'h1);
    wr(`SBPA_OFF_IRQ_EN, 32'h0);
    chk(irq, 1'h0);
    wr(`SBPA_OFF_IRQ_EN, 32'h4);
    wr(`SBPA_OFF_IRQ_CLR, 32'h4);
    chk(irq, 1'h0);
    rd(`SBPA_OFF_IRQ_STS, d, r);
    chk(d, 32'hB);
  endtask
  // reset, then the scenarios
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_arb;
    t_status;
    t_event;
    t_irq;
    end_of_test;
  end
endmodule // test_status_byte_and_port_arbiter
`default_nettype wire
